// File: core/i2ctr_pkg.sv
// constants and types shared by the two-wire target and its bus master
// Behaviour
// - works at 100 kHz and 400 kHz
// - only one master on the bus
// - target may stretch clock; master tolerates it
// - unaddressed target stays in low activity
// - configure only while target disabled
// - reader dma channel only
// - halted only after ram accesses finish
// - enabling places target in idle
// - read: start, address, one, then ack
// - match against up to two addresses
// - ack on match, raise read-addressed event
// - read command detected from idle, address or transmit
// - arm task sets armed; armed read transmits
// - unarmed read stretches clock until armed
// - transmit entry: began event, disarm, send
// - restart during transmit goes straight to address
// - stop: halt, event, disarm, idle
// - past limit send fill byte, error
// - pointer and limit latched at began event
// - halt task: halt, event, disarm, idle
// - master nacks last byte; target releases
// - readable count of bytes sent
package i2ctr_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int RATE_STD_HZ = 100_000;
  localparam int RATE_FAST_HZ = 400_000;
  localparam int SYNC_LEN = 3;
  localparam int ADDR_W = 7;
  localparam int LIM_W = 13;
  localparam logic [7:0] ACK_BIT_MASK = 8'h01;
  // host register offsets and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RXDATA = 4'h8;
  localparam logic [3:0] REG_RXCNT = 4'hc;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CTRL_CNT_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    D_IDLE = 4'h0,
    D_ADDR = 4'h1,
    D_AACK = 4'h2,
    D_WAIT = 4'h3,
    D_FETCH = 4'h4,
    D_BIT = 4'h5,
    D_MACK = 4'h6,
    D_LINGER = 4'h7,
    D_HALT = 4'h8
  } i2ctr_dstate_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BIT = 2'h2,
    H_STOP = 2'h3
  } i2ctr_hstate_t;
endpackage : i2ctr_pkg

// File: core/i2ctr_bus_if.sv
// open-drain two-wire bus joining target and master
`timescale 1ns/1ps
interface i2ctr_bus_if;
  logic dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe;
  logic host_scl_o, host_scl_oe, host_sda_o, host_sda_oe;
  logic scl, sda;
  // wired-and with pull-up: low whenever any end enables its driver
  assign scl = ~(dev_scl_oe | host_scl_oe);
  assign sda = ~(dev_sda_oe | host_sda_oe);
  modport device (input scl, sda,
    output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe);
  modport host (input scl, sda,
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
endinterface : i2ctr_bus_if

// File: core/i2ctr_target.sv
// two-wire target: read path with reader dma
`timescale 1ns/1ps
module i2ctr_target (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic i_arm_transmit_task,
  input wire logic i_halt_task,
  input wire logic [i2ctr_pkg::ADDR_W-1:0] i_addr0,
  input wire logic [i2ctr_pkg::ADDR_W-1:0] i_addr1,
  input wire logic [1:0] i_addr_en,
  input wire logic [31:0] i_transmit_buffer_pointer,
  input wire logic [i2ctr_pkg::LIM_W-1:0] i_transmit_byte_limit,
  input wire logic [7:0] i_overread_fill_byte,
  output logic o_dma_req,
  output logic [31:0] o_dma_addr,
  input wire logic i_dma_ack,
  input wire logic [7:0] i_dma_data,
  output logic o_read_ev,
  output logic o_transmit_began_event,
  output logic o_halted_ev,
  output logic o_error_ev,
  output logic [i2ctr_pkg::LIM_W-1:0] o_transmit_byte_tally,
  output logic o_busy,
  i2ctr_bus_if.device bus
);
  localparam int LW = i2ctr_pkg::LIM_W;

  function automatic logic addr_hit(input logic [6:0] a,
      input logic [6:0] a0, input logic [6:0] a1, input logic [1:0] en);
    addr_hit = (en[0] && a == a0) || (en[1] && a == a1);
  endfunction : addr_hit

  logic [i2ctr_pkg::SYNC_LEN-1:0] scl_s_q, sda_s_q;
  logic scl_f_q, sda_f_q, scl_f_d, sda_f_d;
  logic rise, fall, start_c, stop_c;
  i2ctr_pkg::i2ctr_dstate_t state_q, state_d;
  logic armed_q;
  logic [2:0] bitn_q;
  logic [7:0] sh_q;
  logic [31:0] ptr_q;
  logic [LW-1:0] lim_q, tally_q;
  logic sda_oe_q, scl_oe_q, dma_req_q;
  logic begin_s, halt_s, read_s, err_s, load_s, in_tx;
  logic [7:0] load_byte;

  // pin sampling: a change counts once second and third stage agree
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      scl_s_q <= '1;
      sda_s_q <= '1;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], bus.scl};
      sda_s_q <= {sda_s_q[1:0], bus.sda};
      scl_f_q <= scl_f_d;
      sda_f_q <= sda_f_d;
    end
  end

  // filter keeps up with 10 ns sampling at either bit rate
  assign scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
  assign sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
  assign rise = scl_f_d & ~scl_f_q;
  assign fall = ~scl_f_d & scl_f_q;
  assign start_c = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
  assign stop_c = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;
  assign in_tx = state_q inside {i2ctr_pkg::D_WAIT, i2ctr_pkg::D_FETCH,
      i2ctr_pkg::D_BIT, i2ctr_pkg::D_MACK, i2ctr_pkg::D_LINGER};

  always_comb begin
    state_d = state_q;
    begin_s = 1'b0;
    halt_s = 1'b0;
    read_s = 1'b0;
    err_s = 1'b0;
    load_s = 1'b0;
    load_byte = i_dma_data;
    if (!i_enable) begin
      state_d = i2ctr_pkg::D_IDLE;
    end else if (i_halt_task || (stop_c && in_tx)) begin
      // halted waits for an outstanding fetch to land
      if (dma_req_q) begin
        state_d = i2ctr_pkg::D_HALT;
      end else begin
        state_d = i2ctr_pkg::D_IDLE;
        halt_s = 1'b1;
      end
    end else if (start_c && state_q inside {i2ctr_pkg::D_IDLE,
        i2ctr_pkg::D_ADDR}) begin
      state_d = i2ctr_pkg::D_ADDR;
    end else if (start_c && in_tx) begin
      // restart leaves transmit straight into a new address, skipping idle
      state_d = i2ctr_pkg::D_ADDR;
    end else if (stop_c) begin
      state_d = (state_q == i2ctr_pkg::D_HALT) ? state_q : i2ctr_pkg::D_IDLE;
    end else begin
      case (state_q)
        i2ctr_pkg::D_ADDR: begin
          if (rise && bitn_q == 3'h7) begin
            // direction bit one is a read; writes are not answered
            if (sda_f_d && addr_hit(sh_q[6:0], i_addr0, i_addr1,
                i_addr_en)) begin
              state_d = i2ctr_pkg::D_AACK;
            end else begin
              state_d = i2ctr_pkg::D_IDLE;
            end
          end
        end
        i2ctr_pkg::D_AACK: begin
          if (fall && !sda_oe_q) begin
            read_s = 1'b1;
          end else if (fall) begin
            if (armed_q) begin
              state_d = i2ctr_pkg::D_FETCH;
              begin_s = 1'b1;
            end else begin
              state_d = i2ctr_pkg::D_WAIT;
            end
          end
        end
        i2ctr_pkg::D_WAIT: begin
          if (armed_q) begin
            state_d = i2ctr_pkg::D_FETCH;
            begin_s = 1'b1;
          end
        end
        i2ctr_pkg::D_FETCH: begin
          if (tally_q >= lim_q) begin
            load_byte = i_overread_fill_byte;
            err_s = 1'b1;
            load_s = 1'b1;
            state_d = i2ctr_pkg::D_BIT;
          end else if (dma_req_q && i_dma_ack) begin
            load_s = 1'b1;
            state_d = i2ctr_pkg::D_BIT;
          end
        end
        i2ctr_pkg::D_BIT: begin
          if (fall && bitn_q == 3'h7) begin
            state_d = i2ctr_pkg::D_MACK;
          end
        end
        i2ctr_pkg::D_MACK: begin
          if (rise && sda_f_d) begin
            state_d = i2ctr_pkg::D_LINGER;
          end else if (fall) begin
            state_d = i2ctr_pkg::D_FETCH;
          end
        end
        i2ctr_pkg::D_HALT: begin
          if (!dma_req_q) begin
            state_d = i2ctr_pkg::D_IDLE;
            halt_s = 1'b1;
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= i2ctr_pkg::D_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // armed flag: a task in the same cycle as the clear wins
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_enable) begin
      armed_q <= 1'b0;
    end else if (i_arm_transmit_task) begin
      armed_q <= 1'b1;
    end else if (begin_s || halt_s) begin
      armed_q <= 1'b0;
    end
  end

  // address shift runs only once a start is seen
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bitn_q <= 3'h0;
      sh_q <= 8'h00;
    end else if (start_c && state_d == i2ctr_pkg::D_ADDR) begin
      bitn_q <= 3'h0;
    end else if (state_q == i2ctr_pkg::D_ADDR && rise) begin
      sh_q <= {sh_q[6:0], sda_f_d};
      bitn_q <= bitn_q + 3'h1;
    end else if (load_s) begin
      sh_q <= load_byte;
      bitn_q <= 3'h0;
    end else if (state_q == i2ctr_pkg::D_BIT && fall) begin
      sh_q <= {sh_q[6:0], 1'b1};
      bitn_q <= bitn_q + 3'h1;
    end
  end

  // working copies, latched with the began event
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ptr_q <= 32'h0;
      lim_q <= '0;
      tally_q <= '0;
    end else if (begin_s) begin
      ptr_q <= i_transmit_buffer_pointer;
      lim_q <= i_transmit_byte_limit;
      tally_q <= '0;
    end else if (state_q == i2ctr_pkg::D_MACK && rise) begin
      tally_q <= tally_q + LW'(1);
    end
  end

  // reader channel: one byte per request, held until acknowledged
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dma_req_q <= 1'b0;
      o_dma_addr <= 32'h0;
    end else if (dma_req_q) begin
      dma_req_q <= ~i_dma_ack;
    end else if (state_q == i2ctr_pkg::D_FETCH && tally_q < lim_q &&
        state_d == i2ctr_pkg::D_FETCH) begin
      dma_req_q <= 1'b1;
      o_dma_addr <= ptr_q + 32'(tally_q);
    end
  end

  // line drivers; scl is let go a cycle after the first bit is set
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_enable) begin
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= state_q inside {i2ctr_pkg::D_WAIT,
          i2ctr_pkg::D_FETCH};
      if (state_d == i2ctr_pkg::D_AACK) begin
        sda_oe_q <= (state_q == i2ctr_pkg::D_AACK) ? (sda_oe_q | fall) :
            1'b0;
      end else if (load_s) begin
        sda_oe_q <= ~load_byte[7];
      end else if (state_d == i2ctr_pkg::D_BIT && fall) begin
        sda_oe_q <= ~sh_q[6];
      end else if (state_d != i2ctr_pkg::D_BIT) begin
        // a data bit stands until the next fall; released otherwise
        sda_oe_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_read_ev <= 1'b0;
      o_transmit_began_event <= 1'b0;
      o_halted_ev <= 1'b0;
      o_error_ev <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_read_ev <= read_s;
      o_transmit_began_event <= begin_s;
      o_halted_ev <= halt_s;
      o_error_ev <= err_s;
      o_busy <= state_d != i2ctr_pkg::D_IDLE;
    end
  end

  assign o_dma_req = dma_req_q;
  assign o_transmit_byte_tally = tally_q;
  assign bus.dev_scl_oe = scl_oe_q;
  assign bus.dev_sda_oe = sda_oe_q;
  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_o = 1'b0;
endmodule : i2ctr_target

// File: core/i2ctr_master.sv
// single bus master driving read commands, run over axi4-lite
`timescale 1ns/1ps
module i2ctr_master #(
  parameter int RATE_HZ = i2ctr_pkg::RATE_STD_HZ
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [31:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  i2ctr_bus_if.host bus
);
  localparam int QTR = i2ctr_pkg::CLK_HZ / (4 * RATE_HZ);
  localparam logic [11:0] QTR_C = 12'(QTR);
  if (RATE_HZ != i2ctr_pkg::RATE_STD_HZ &&
      RATE_HZ != i2ctr_pkg::RATE_FAST_HZ) begin : g_bad_rate
    $error("unsupported bit rate");
  end

  logic [i2ctr_pkg::SYNC_LEN-1:0] scl_s_q, sda_s_q;
  logic scl_f_q, sda_f_q;
  i2ctr_pkg::i2ctr_hstate_t st_q;
  logic [1:0] ph_q;
  logic [11:0] tm_q;
  logic [3:0] fbit_q;
  logic [8:0] txw_q;
  logic [7:0] rxw_q, rxdata_q, left_q, rxcnt_q;
  logic [6:0] addr_q;
  logic afr_q, nack_q, go, tick;
  logic aw_got_q, w_got_q;
  logic [3:0] aw_off_q;
  logic [31:0] wdata_q;
  logic scl_oe_q, sda_oe_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      scl_s_q <= '1;
      sda_s_q <= '1;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], bus.scl};
      sda_s_q <= {sda_s_q[1:0], bus.sda};
      if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
    end
  end

  // write slave: address and data in either order, then response
  assign go = aw_got_q && w_got_q && !o_bvalid &&
      aw_off_q == i2ctr_pkg::REG_CTRL && i_wstrb[0] &&
      wdata_q[i2ctr_pkg::CTRL_GO_BIT] && st_q == i2ctr_pkg::H_IDLE &&
      wdata_q[i2ctr_pkg::CTRL_CNT_LSB +: 8] != 8'h00;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_off_q <= 4'h0;
      wdata_q <= 32'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= i2ctr_pkg::RESP_OKAY;
    end else begin
      o_awready <= !aw_got_q && !(i_awvalid && o_awready);
      o_wready <= !w_got_q && !(i_wvalid && o_wready);
      if (i_awvalid && o_awready) begin
        aw_got_q <= 1'b1;
        aw_off_q <= i_awaddr[3:0];
      end
      if (i_wvalid && o_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= i_wdata;
      end
      if (aw_got_q && w_got_q && !o_bvalid) begin
        o_bvalid <= 1'b1;
        o_bresp <= (aw_off_q == i2ctr_pkg::REG_CTRL) ?
            i2ctr_pkg::RESP_OKAY : i2ctr_pkg::RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= i2ctr_pkg::RESP_OKAY;
    end else if (o_rvalid) begin
      o_rvalid <= ~i_rready;
      o_arready <= i_rready;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= i2ctr_pkg::RESP_OKAY;
      case (i_araddr[3:0])
        i2ctr_pkg::REG_STATUS: begin
          o_rdata <= 32'({nack_q, st_q != i2ctr_pkg::H_IDLE});
        end
        i2ctr_pkg::REG_RXDATA: o_rdata <= 32'(rxdata_q);
        i2ctr_pkg::REG_RXCNT: o_rdata <= 32'(rxcnt_q);
        default: begin
          o_rdata <= 32'h0;
          o_rresp <= i2ctr_pkg::RESP_SLVERR;
        end
      endcase
    end else begin
      o_arready <= 1'b1;
    end
  end

  // bit engine: quarter-period phases from the divider
  assign tick = tm_q == 12'h0;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_q <= i2ctr_pkg::H_IDLE;
      ph_q <= 2'h0;
      tm_q <= 12'h0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      fbit_q <= 4'h0;
      txw_q <= 9'h1ff;
      rxw_q <= 8'h00;
      rxdata_q <= 8'h00;
      rxcnt_q <= 8'h00;
      left_q <= 8'h00;
      addr_q <= 7'h00;
      afr_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      if (!tick) tm_q <= tm_q - 12'h1;
      case (st_q)
        i2ctr_pkg::H_IDLE: begin
          if (go) begin
            st_q <= i2ctr_pkg::H_START;
            addr_q <= wdata_q[i2ctr_pkg::CTRL_ADDR_LSB +: 7];
            left_q <= wdata_q[i2ctr_pkg::CTRL_CNT_LSB +: 8];
            rxcnt_q <= 8'h00;
            nack_q <= 1'b0;
            ph_q <= 2'h0;
            tm_q <= QTR_C;
          end
        end
        i2ctr_pkg::H_START: begin
          if (tick && ph_q == 2'h0) begin
            sda_oe_q <= 1'b1;
            ph_q <= 2'h1;
            tm_q <= QTR_C;
          end else if (tick) begin
            scl_oe_q <= 1'b1;
            st_q <= i2ctr_pkg::H_BIT;
            txw_q <= {addr_q, 1'b1, 1'b1};
            afr_q <= 1'b1;
            fbit_q <= 4'h0;
            ph_q <= 2'h0;
          end
        end
        i2ctr_pkg::H_BIT: begin
          if (ph_q == 2'h0 && tick) begin
            sda_oe_q <= ~txw_q[8];
            ph_q <= 2'h1;
            tm_q <= QTR_C + QTR_C;
          end else if (ph_q == 2'h1 && tick) begin
            scl_oe_q <= 1'b0;
            ph_q <= 2'h2;
          end else if (ph_q == 2'h2 && scl_f_q) begin
            ph_q <= 2'h3;
            tm_q <= QTR_C + QTR_C;
          end else if (ph_q == 2'h3 && tick) begin
            scl_oe_q <= 1'b1;
            ph_q <= 2'h0;
            txw_q <= {txw_q[7:0], 1'b1};
            rxw_q <= {rxw_q[6:0], sda_f_q};
            fbit_q <= fbit_q + 4'h1;
            if (fbit_q == 4'h8) begin
              fbit_q <= 4'h0;
              if (afr_q && sda_f_q) begin
                nack_q <= 1'b1;
                st_q <= i2ctr_pkg::H_STOP;
              end else if (!afr_q && left_q == 8'h01) begin
                st_q <= i2ctr_pkg::H_STOP;
              end
              if (!afr_q) begin
                rxdata_q <= rxw_q;
                rxcnt_q <= rxcnt_q + 8'h01;
                left_q <= left_q - 8'h01;
              end
              afr_q <= 1'b0;
              // last wanted byte is answered with a nack
              txw_q <= {8'hff, (afr_q ? left_q : left_q - 8'h01) ==
                  8'h01};
            end
          end
        end
        i2ctr_pkg::H_STOP: begin
          if (ph_q == 2'h0 && tick) begin
            sda_oe_q <= 1'b1;
            ph_q <= 2'h1;
            tm_q <= QTR_C;
          end else if (ph_q == 2'h1 && tick) begin
            scl_oe_q <= 1'b0;
            ph_q <= 2'h2;
          end else if (ph_q == 2'h2 && scl_f_q) begin
            ph_q <= 2'h3;
            tm_q <= QTR_C;
          end else if (ph_q == 2'h3 && tick) begin
            sda_oe_q <= 1'b0;
            st_q <= i2ctr_pkg::H_IDLE;
            ph_q <= 2'h0;
          end
        end
        default: st_q <= i2ctr_pkg::H_IDLE;
      endcase
    end
  end

  assign bus.host_scl_oe = scl_oe_q;
  assign bus.host_sda_oe = sda_oe_q;
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
endmodule : i2ctr_master

// File: verif/i2ctr_monitor.sv
// assertions on the shared two-wire bus between target and master
`timescale 1ns/1ps
module i2ctr_monitor (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_high;
    scl && $past(scl);
  endsequence
  sequence s_start;
    s_high ##0 $fell(sda);
  endsequence
  sequence s_stop;
    s_high ##0 $rose(sda);
  endsequence
  AST_RST_REL: assert property (disable iff (1'b0) i_reset |=>
    !dev_scl_oe && !dev_sda_oe && !host_scl_oe && !host_sda_oe)
    else $error("bus still driven after reset");
  AST_BIT_FIRST: assert property ($fell(dev_scl_oe) |->
    $stable(dev_sda_oe))
    else $error("clock let go in the cycle the data bit moved");
  AST_DEV_SDA: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target moved data while clock high");
  AST_STRETCH: assert property ($rose(dev_scl_oe) |-> !$past(scl))
    else $error("target pulled a high clock low");
  AST_HOST_WAIT: assert property ($rose(host_scl_oe) |-> $past(scl))
    else $error("master ended a stretched clock");
  AST_START: assert property (s_start |-> host_sda_oe && !dev_sda_oe)
    else $error("start not made by master");
  AST_STOP: assert property (s_stop |-> !dev_sda_oe && !dev_scl_oe)
    else $error("target holds bus at stop");
  AST_SDA_HOLD: assert property (s_high ##0 $changed(sda) |->
    $changed(host_sda_oe))
    else $error("data changed while clock high");
  cover property ($rose(dev_scl_oe));
endmodule : i2ctr_monitor

// File: verif/test_i2c_target_read_path_dma.sv
// self-checking bench: master reads from the target over the shared bus
`timescale 1ns/1ps
module test_i2c_target_read_path_dma;
  typedef struct packed {
    logic [6:0] adr;
    logic [1:0] aen;
    logic [7:0] cnt;
    logic [12:0] lim;
  } i2ctr_row_t;
  localparam logic [6:0] A0 = 7'h2a;
  localparam logic [6:0] A1 = 7'h51;
  localparam logic [7:0] FILL = 8'hc3;
  localparam i2ctr_row_t ROWS [6] = '{'{7'h13, 2'h3, 8'h1, 13'h4},
    '{7'h51, 2'h1, 8'h1, 13'h4}, '{7'h2a, 2'h1, 8'h1, 13'h4},
    '{7'h51, 2'h2, 8'h3, 13'h4}, '{7'h2a, 2'h3, 8'h4, 13'h4},
    '{7'h2a, 2'h3, 8'h3, 13'h1}};
  logic i_clk = 0;
  logic i_reset = 1;
  logic en = 1, arm = 0, hlt = 0, ack = 0, stall = 0;
  logic [1:0] aen = 2'h3;
  logic [12:0] lim = 13'h4;
  logic [31:0] ptr = 32'h100;
  logic [7:0] ddat = 8'h0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [31:0] awa = 0, wd = 0, ara = 0;
  logic dreq, rd_ev, tb_ev, hl_ev, er_ev, busy;
  logic awr, wr, bv, arr, rv;
  logic [1:0] br, rr;
  logic [31:0] dadr, rdat;
  logic [12:0] tally;
  logic [7:0] ev [4];
  logic [7:0] base [4];
  int err_total = 0, num_checks = 0, cyc = 0;
  i2ctr_bus_if bus ();
  i2ctr_target u_i2ctr_target (.i_clk(i_clk), .i_reset(i_reset),
    .i_enable(en), .i_arm_transmit_task(arm), .i_halt_task(hlt),
    .i_addr0(A0), .i_addr1(A1), .i_addr_en(aen),
    .i_transmit_buffer_pointer(ptr), .i_transmit_byte_limit(lim),
    .i_overread_fill_byte(FILL), .o_dma_req(dreq), .o_dma_addr(dadr),
    .i_dma_ack(ack), .i_dma_data(ddat), .o_read_ev(rd_ev),
    .o_transmit_began_event(tb_ev), .o_halted_ev(hl_ev),
    .o_error_ev(er_ev), .o_transmit_byte_tally(tally), .o_busy(busy),
    .bus(bus));
  i2ctr_master #(.RATE_HZ(i2ctr_pkg::RATE_FAST_HZ)) u_i2ctr_master (
    .i_clk(i_clk), .i_reset(i_reset), .i_awvalid(awv), .o_awready(awr),
    .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr), .i_wdata(wd),
    .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(bry), .o_bresp(br),
    .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
    .i_rready(rry), .o_rdata(rdat), .o_rresp(rr), .bus(bus));
  i2ctr_monitor u_i2ctr_monitor (.i_clk(i_clk), .i_reset(i_reset),
    .dev_scl_oe(bus.dev_scl_oe), .dev_sda_oe(bus.dev_sda_oe),
    .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe),
    .scl(bus.scl), .sda(bus.sda));
  function automatic logic [7:0] dat(input logic [31:0] a);
    return a[7:0] + 8'h33;
  endfunction : dat
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  always #5 i_clk = ~i_clk;
  // ram model; pointer moves after each latch so a late capture shows
  always @(posedge i_clk) begin
    ack <= dreq && !ack && !stall;
    ddat <= dat(dadr);
    if (tb_ev === 1'b1) ptr <= ptr + 32'h10;
    if (i_reset) ev <= '{default: 8'h0};
    else ev <= '{ev[0] + {7'h0, rd_ev}, ev[1] + {7'h0, tb_ev},
      ev[2] + {7'h0, hl_ev}, ev[3] + {7'h0, er_ev}};
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_resp(input string n, input logic [1:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_resp
  task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
    @(posedge i_clk);
    awv <= 1;
    awa <= a;
    wv <= 1;
    wd <= d;
    bry <= 1;
    do begin
      @(posedge i_clk);
      if (awr === 1'b1) awv <= 0;
      if (wr === 1'b1) wv <= 0;
    end while (bv !== 1'b1);
    r = br;
    bry <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge i_clk);
    arv <= 1;
    ara <= a;
    rry <= 1;
    do begin
      @(posedge i_clk);
      if (arr === 1'b1) arv <= 0;
    end while (rv !== 1'b1);
    d = rdat;
    r = rr;
    rry <= 0;
  endtask : axi_rd
  task automatic go(input logic [6:0] a, input logic [7:0] c);
    logic [1:0] r;
    axi_wr(32'h0, {8'h0, c, 1'b0, a, 8'h1}, r);
    chk_resp("ctrl write", i2ctr_pkg::RESP_OKAY, r);
  endtask : go
  task automatic fin(output logic [31:0] d);
    logic [1:0] r;
    repeat (8) @(posedge i_clk);
    do axi_rd(32'h4, d, r);
    while (d[0] !== 1'b0);
    repeat (20) @(posedge i_clk);
  endtask : fin
  task automatic pulse_arm();
    @(posedge i_clk);
    arm <= 1;
    @(posedge i_clk);
    arm <= 0;
  endtask : pulse_arm
  initial begin
    logic m;
    logic [7:0] x, c;
    logic [31:0] p, d;
    logic [1:0] r;
    repeat (6) @(posedge i_clk);
    i_reset <= 0;
    repeat (4) @(posedge i_clk);
    chk("tally", 32'h0, 32'(tally));
    chk("busy", 32'h0, 32'(busy));
    for (int i = 0; i < 6; i++) begin
      c = ROWS[i].cnt;
      m = (ROWS[i].aen[0] && ROWS[i].adr == A0) ||
        (ROWS[i].aen[1] && ROWS[i].adr == A1);
      p = ptr;
      x = (13'(c) <= ROWS[i].lim) ? dat(p + 32'(c) - 32'h1) : FILL;
      @(posedge i_clk);
      en <= 0;
      aen <= ROWS[i].aen;
      lim <= ROWS[i].lim;
      @(posedge i_clk);
      en <= 1;
      if (m) pulse_arm();
      base = ev;
      go(ROWS[i].adr, c);
      fin(d);
      chk("nack", 32'(!m), 32'(d[1]));
      chk("read ev", 32'(m), 32'(ev[0] - base[0]));
      chk("began ev", 32'(m), 32'(ev[1] - base[1]));
      chk("halted ev", 32'(m), 32'(ev[2] - base[2]));
      if (m) begin
        chk("err ev", (c > ROWS[i].lim) ? 32'(c) - 32'(ROWS[i].lim) : 0,
          32'(ev[3] - base[3]));
        chk("tally", 32'(c), 32'(tally));
        axi_rd(32'h8, d, r);
        chk("last byte", 32'(x), d);
        axi_rd(32'hc, d, r);
        chk("rx count", 32'(c), d);
      end
    end
    base = ev;
    p = ptr;
    go(A0, 8'h1);
    repeat (3000) @(posedge i_clk);
    chk("scl held", 32'h0, 32'(bus.scl));
    chk("began early", 32'h0, 32'(ev[1] - base[1]));
    pulse_arm();
    fin(d);
    chk("began late", 32'h1, 32'(ev[1] - base[1]));
    axi_rd(32'h8, d, r);
    chk("stretched byte", 32'(dat(p)), d);
    // halt while a fetch is outstanding: halted waits for the ack
    stall <= 1;
    pulse_arm();
    base = ev;
    go(A0, 8'h1);
    while (dreq !== 1'b1) @(posedge i_clk);
    hlt <= 1;
    @(posedge i_clk);
    hlt <= 0;
    repeat (20) @(posedge i_clk);
    chk("halt early", 32'h0, 32'(ev[2] - base[2]));
    stall <= 0;
    fin(d);
    chk("halt late", 32'h1, 32'(ev[2] - base[2]));
    en <= 0;
    base = ev;
    go(A0, 8'h1);
    fin(d);
    chk("off nack", 32'h1, 32'(d[1]));
    chk("off read ev", 32'h0, 32'(ev[0] - base[0]));
    en <= 1;
    base = ev;
    @(posedge i_clk);
    hlt <= 1;
    @(posedge i_clk);
    hlt <= 0;
    repeat (6) @(posedge i_clk);
    chk("halt ev", 32'h1, 32'(ev[2] - base[2]));
    chk("halt busy", 32'h0, 32'(busy));
    axi_rd(32'h10, d, r);
    chk_resp("unmapped rd", i2ctr_pkg::RESP_SLVERR, r);
    chk("unmapped data", 32'h0, d);
    axi_rd(32'h0, d, r);
    chk_resp("ctrl rd", i2ctr_pkg::RESP_SLVERR, r);
    axi_wr(32'h4, 32'h1, r);
    chk_resp("status wr", i2ctr_pkg::RESP_SLVERR, r);
    stop_test();
  end
endmodule : test_i2c_target_read_path_dma
